/* src/dcmc_top.sv */
// Dual clock mode controller: clock sources, instruction rate, power modes,
// watchdog clock and prescale, with one control register over APB.
// Assumes oscillator outputs, wake pin and straps arrive asynchronously;
// the APB master runs on ref_clk_i.
//
// Behaviour
// R1: Normal mode, external crystal high clock: instruction rate is high clock over 4.
// R2: Normal mode, internal fast RC high clock: instruction rate is high clock over 16.
// R3: Slow mode uses low clock, instruction rate is low clock over 4.
// R4: Bit one set stops the high oscillator, low clock keeps running.
// R5: Bit two picks system clock: zero high clock, one low clock.
// R6: Mode field bits four..three: 00 normal, 01 sleep, 10 green, 11 reserved.
// R7: Bit five picks watchdog prescale: zero 2^14, one 2^8.
// R8: Writing one to bit six clears the watchdog counter; zero does nothing.
// R9: Bit seven picks watchdog clock: zero instruction rate, one low RC.
// R10: Always-on low RC option forces the watchdog clock select bit to one.
// R11: Overflow after further divide by 16; low RC source prescales by 512.
// R12: Sleep stops both the high oscillator and the low RC; the code keeps the low RC running when the always-on option is set.
// R13: Low clock has no own disable; only the mode field stops it.
// R14: High clock option: fast RC, fast RC plus crystal, or external oscillator.
// R15: With fast RC plus crystal, low clock comes from that crystal, else low RC.
// R16: External clock signal option clocks from input pin, frees output pin.
// R17: Low RC serves both as watchdog clock and as slow system clock.
// R18: Wake from sleep waits 2048 high clocks before normal mode resumes.
// R19: Green mode stops execution, low clock runs, high clock per bit one.
// R20: Switching between high and low system clock never shortens a pulse.
// R21: Reserved mode acts as normal; bit zero always reads zero.
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
module dcmc_top
  import dcmc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              arst_n_i,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Oscillator sources and wake pin
  input  wire logic              fast_rc_clk_i,
  input  wire logic              osc_in_pin_i,
  input  wire logic              slow_rc_clk_i,
  input  wire logic              wake_i,
  // Build options
  input  wire logic [1:0]        high_clk_option_i,
  input  wire logic              slow_rc_always_on_i,
  // Oscillator and pin control
  output logic                   high_osc_enable_o,
  output logic                   slow_osc_enable_o,
  output logic                   osc_in_pin_gpio_o,
  output logic                   osc_out_pin_gpio_o,
  // Core clocking
  output logic                   cpu_tick_o,
  output logic                   instr_tick_o,
  output logic                   cpu_run_o,
  // Watchdog
  output logic                   watchdog_clear_o,
  output logic                   watchdog_overflow_o
);
  `include "dcmc_cfg.svh"

  // Refused at elaboration: the decoder needs the whole register address
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_addr_w_bad
    $error("dcmc_top: ADDR_W must lie in 12..32");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  dcmc_state_t st;
  dcmc_state_t next_st;
  dcmc_ctl_t   ctl;

  logic [6:0]  rise;
  logic        hi_tick;
  logic        lo_tick;
  logic        lrc_tick;
  logic        sys_tick;
  logic        rc_high;
  logic [3:0]  div_last;
  logic        wdt_src;
  logic [13:0] pre_last;
  logic        hit;
  logic        wr;
  logic        rd_hit;
  logic [1:0]  mode;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // Zero wait states: every access completes in its first access cycle.
  assign hit     = (paddr == ADDR_W'(`DCMC_CTRL_ADDR));
  assign wr      = psel && penable && pwrite && hit && pstrb[0];
  assign rd_hit  = psel && !pwrite && hit;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = rd_hit ? {24'h00_0000, st.ctrl[7:1], 1'b0} : 32'h0000_0000; // R21

  // --------------------------------------------------------------------------
  // Source selection
  // --------------------------------------------------------------------------
  assign rise     = st.sync_b & ~st.sync_c;
  assign mode     = st.ctrl[`DCMC_F_MODE_HI:`DCMC_F_MODE_LO];
  assign rc_high  = (st.opt == `DCMC_OPT_RC) || (st.opt == `DCMC_OPT_RC_XTAL); // R14
  assign hi_tick  = (rc_high ? rise[0] : rise[1]) && ctl.hosc_en;              // R16
  assign lrc_tick = rise[2] && ctl.losc_en;
  assign lo_tick  = ((st.opt == `DCMC_OPT_RC_XTAL) ? rise[1] : rise[2])
                    && ctl.losc_en;                                            // R15
  assign sys_tick = st.sel_low ? lo_tick : hi_tick;                            // R17

  always_comb begin
    if (st.sel_low) begin
      div_last = `DCMC_DIV_SLOW;                                               // R3
    end else if (rc_high) begin
      div_last = `DCMC_DIV_RC;                                                 // R2
    end else begin
      div_last = `DCMC_DIV_EXT;                                                // R1
    end
  end

  // Low RC prescale ignores the rate bit
  assign wdt_src = st.ctrl[`DCMC_F_WSEL] ? lrc_tick : st.cpu_tick;             // R9
  always_comb begin
    if (st.ctrl[`DCMC_F_WSEL]) begin
      pre_last = `DCMC_WPRE_LRC;                                               // R11
    end else if (st.ctrl[`DCMC_F_RATE]) begin
      pre_last = `DCMC_WPRE_SHORT;                                             // R7
    end else begin
      pre_last = `DCMC_WPRE_LONG;                                              // R7
    end
  end

  // --------------------------------------------------------------------------
  // Oscillator and pin control
  // --------------------------------------------------------------------------
  always_comb begin
    ctl.hosc_en  = (st.pwr == DCMC_WAKE)
                   || ((st.pwr == DCMC_RUN) && !st.ctrl[`DCMC_F_HSTOP]);       // R4
    // No software disable for the low clock, only sleep
    ctl.losc_en  = (st.pwr != DCMC_SLEEP) || st.aon;                           // R13
    ctl.cpu_run  = (st.pwr == DCMC_RUN) && (mode != `DCMC_MODE_GREEN);         // R19
    ctl.in_gpio  = st.strap_done && (st.opt == `DCMC_OPT_RC);
    ctl.out_gpio = st.strap_done
                   && ((st.opt == `DCMC_OPT_RC) || (st.opt == `DCMC_OPT_EXT_CLK)); // R16
  end

  assign high_osc_enable_o   = ctl.hosc_en;
  assign slow_osc_enable_o   = ctl.losc_en;
  assign osc_in_pin_gpio_o   = ctl.in_gpio;
  assign osc_out_pin_gpio_o  = ctl.out_gpio;
  assign cpu_run_o           = ctl.cpu_run;
  assign cpu_tick_o          = st.cpu_tick;
  assign instr_tick_o        = st.ins_tick;
  assign watchdog_clear_o    = st.wdt_clr;
  assign watchdog_overflow_o = st.wdt_ovf;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_st          = st;
    next_st.sync_a   = {high_clk_option_i, slow_rc_always_on_i, wake_i,
                        slow_rc_clk_i, osc_in_pin_i, fast_rc_clk_i};
    next_st.sync_b   = st.sync_a;
    next_st.sync_c   = st.sync_b;
    next_st.cpu_tick = 1'b0;
    next_st.ins_tick = 1'b0;
    next_st.wdt_ovf  = 1'b0;
    next_st.wdt_clr  = 1'b0;

    // Straps taken once, after the synchroniser has filled
    if (!st.strap_done) begin
      if (st.strap_cnt == `DCMC_STRAP_LAST) begin
        next_st.strap_done = 1'b1;
        next_st.opt        = st.sync_b[6:5];
        next_st.aon        = st.sync_b[4];
      end else begin
        next_st.strap_cnt = st.strap_cnt + 2'h1;
      end
    end

    // Register write
    if (wr) begin
      next_st.ctrl = pwdata[7:0];
      next_st.ctrl[`DCMC_F_ZERO] = 1'b0;                                       // R21
      if (pwdata[`DCMC_F_WCLR]) begin
        next_st.wdt_clr = 1'b1;                                                // R8
      end
    end
    if (st.aon) begin
      next_st.ctrl[`DCMC_F_WSEL] = 1'b1;                                       // R10
    end

    // Instruction rate divider; source swaps only at a period boundary
    if (sys_tick) begin
      if (st.cpu_div >= div_last) begin
        next_st.cpu_div  = 4'h0;
        next_st.cpu_tick = 1'b1;
        next_st.ins_tick = ctl.cpu_run;                                        // R19
      end else begin
        next_st.cpu_div = st.cpu_div + 4'h1;
      end
    end
    if (st.cpu_div == 4'h0 && !sys_tick) begin                                 // R5
      next_st.sel_low = st.ctrl[`DCMC_F_SLOW];                                 // R20
    end

    // Watchdog prescale and overflow divide
    if (st.wdt_clr) begin
      next_st.wdt_pre = 14'h0000;                                              // R8
      next_st.wdt_cnt = 4'h0;
    end else if (wdt_src) begin
      if (st.wdt_pre >= pre_last) begin
        next_st.wdt_pre = 14'h0000;
        next_st.wdt_cnt = st.wdt_cnt + 4'h1;
        if (st.wdt_cnt == `DCMC_WOVF_LAST) begin
          next_st.wdt_ovf = 1'b1;                                              // R11
        end
      end else begin
        next_st.wdt_pre = st.wdt_pre + 14'h0001;
      end
    end

    // Power sequencing
    case (st.pwr)
      DCMC_RUN: begin
        // Reserved mode code falls through as normal
        if (mode == `DCMC_MODE_SLEEP) begin
          next_st.pwr = DCMC_SLEEP;                                            // R12
        end else if (mode == `DCMC_MODE_GREEN && st.sync_b[3]) begin
          next_st.ctrl[`DCMC_F_MODE_HI:`DCMC_F_MODE_LO] = `DCMC_MODE_NORMAL;   // R6
        end
      end
      DCMC_SLEEP: begin
        if (st.sync_b[3]) begin
          next_st.pwr      = DCMC_WAKE;
          next_st.wake_cnt = 11'h000;
        end
      end
      DCMC_WAKE: begin
        // Counts only real high clock edges, so start-up time adds on top
        if (hi_tick) begin
          if (st.wake_cnt == `DCMC_WAKE_LAST) begin
            next_st.pwr = DCMC_RUN;                                            // R18
            next_st.ctrl[`DCMC_F_MODE_HI:`DCMC_F_MODE_LO] = `DCMC_MODE_NORMAL;
          end else begin
            next_st.wake_cnt = st.wake_cnt + 11'h001;
          end
        end
      end
      default: begin
        next_st.pwr = DCMC_RUN;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st            <= '0;
      st.ctrl       <= `DCMC_CTRL_RESET;
      st.pwr        <= DCMC_RUN;
    end else begin
      st <= next_st;
    end
  end

endmodule // dcmc_top

/* include/dcmc_cfg.svh */
// Constants of the dual clock mode controller: map, fields, divisors, counts.
// Assumes inclusion by the package and the design file, by bare name.
`ifndef DCMC_CFG_SVH
`define DCMC_CFG_SVH
// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define DCMC_CTRL_INDEX     12'h00ca
`define DCMC_CTRL_ADDR     12'h0328
`define DCMC_CTRL_RESET    8'h00
// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define DCMC_F_ZERO        0
`define DCMC_F_HSTOP       1
`define DCMC_F_SLOW        2
`define DCMC_F_MODE_LO     3
`define DCMC_F_MODE_HI     4
`define DCMC_F_RATE        5
`define DCMC_F_WCLR        6
`define DCMC_F_WSEL        7
`define DCMC_MODE_NORMAL   2'h0
`define DCMC_MODE_SLEEP    2'h1
`define DCMC_MODE_GREEN    2'h2
// ----------------------------------------------------------------------------
// Clock options and divisors
// ----------------------------------------------------------------------------
`define DCMC_OPT_RC        2'h0
`define DCMC_OPT_RC_XTAL   2'h1
`define DCMC_OPT_EXT_XTAL  2'h2
`define DCMC_OPT_EXT_CLK   2'h3
`define DCMC_DIV_EXT       4'h3
`define DCMC_DIV_RC        4'hf
`define DCMC_DIV_SLOW      4'h3
`define DCMC_WPRE_LONG     14'h3fff
`define DCMC_WPRE_SHORT    14'h00ff
`define DCMC_WPRE_LRC      14'h01ff
`define DCMC_WOVF_LAST     4'hf
`define DCMC_WAKE_LAST     11'h7ff
`define DCMC_STRAP_LAST    2'h3
`endif

/* include/dcmc_pkg.sv */
// Types of the dual clock mode controller.
// Assumes dcmc_cfg.svh on the include path.
package dcmc_pkg;
  `include "dcmc_cfg.svh"

  // --------------------------------------------------------------------------
  // Power state and block state
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    DCMC_RUN   = 3'b001,
    DCMC_SLEEP = 3'b010,
    DCMC_WAKE  = 3'b100
  } dcmc_pwr_t;

  typedef struct packed {
    logic [6:0]  sync_a;
    logic [6:0]  sync_b;
    logic [6:0]  sync_c;
    logic [1:0]  strap_cnt;
    logic        strap_done;
    logic [1:0]  opt;
    logic        aon;
    logic [7:0]  ctrl;
    logic        sel_low;
    logic [3:0]  cpu_div;
    logic        cpu_tick;
    logic        ins_tick;
    logic [13:0] wdt_pre;
    logic [3:0]  wdt_cnt;
    logic        wdt_ovf;
    logic        wdt_clr;
    logic [10:0] wake_cnt;
    dcmc_pwr_t   pwr;
  } dcmc_state_t;

  typedef struct packed {
    logic        hosc_en;
    logic        losc_en;
    logic        cpu_run;
    logic        in_gpio;
    logic        out_gpio;
  } dcmc_ctl_t;
endpackage

/* bench/dcmc_osc_model.sv */
// Oscillator sources facing the controller: fast RC, osc pin, slow RC.
// Assumes ref_clk_i as time base; half periods count its cycles.
`timescale 1ns/100ps
module dcmc_osc_model #(
  parameter int HALF_FAST = 3,
  parameter int HALF_XTAL = 4,
  parameter int HALF_SLOW = 3
) (
  // Time base and enables
  input  wire logic       ref_clk_i,
  input  wire logic       high_osc_enable_i,
  input  wire logic       slow_osc_enable_i,
  input  wire logic [1:0] high_clk_option_i,
  // Waveforms
  output logic            fast_rc_clk_o,
  output logic            osc_in_pin_o,
  output logic            slow_rc_clk_o
);
  // ----------------------------------------------------------------------------
  // Sources
  // ----------------------------------------------------------------------------
  int   cf = 0;
  int   cx = 0;
  int   cs = 0;
  logic xen;
  // Pin crystal is the low clock in option 1
  assign xen = (high_clk_option_i == 2'h1) ? slow_osc_enable_i : high_osc_enable_i;
  // A stopped oscillator sits low, it never holds a half cycle
  always @(posedge ref_clk_i) begin
    cf <= high_osc_enable_i ? (cf + 1) % (2 * HALF_FAST) : 0;
    cx <= xen ? (cx + 1) % (2 * HALF_XTAL) : 0;
    cs <= slow_osc_enable_i ? (cs + 1) % (2 * HALF_SLOW) : 0;
  end
  assign fast_rc_clk_o = high_osc_enable_i && cf >= HALF_FAST;
  assign osc_in_pin_o  = xen && cx >= HALF_XTAL;
  assign slow_rc_clk_o = slow_osc_enable_i && cs >= HALF_SLOW;
endmodule // dcmc_osc_model

/* bench/dcmc_top_properties.sv */
// Checker of register reads, oscillator enables and tick pulses.
// Assumes binding onto dcmc_top; sees its ports only.
`timescale 1ns/100ps
`include "dcmc_cfg.svh"
module dcmc_top_properties #(
  parameter int ADDR_W = 12
) (
  // Clock, reset, APB
  input wire logic              ref_clk_i,
  input wire logic              arst_n_i,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  // Pins and straps
  input wire logic              wake_i,
  input wire logic [1:0]        high_clk_option_i,
  input wire logic              slow_rc_always_on_i,
  // Outputs
  input wire logic              high_osc_enable_o,
  input wire logic              slow_osc_enable_o,
  input wire logic              osc_in_pin_gpio_o,
  input wire logic              osc_out_pin_gpio_o,
  input wire logic              cpu_tick_o,
  input wire logic              instr_tick_o,
  input wire logic              watchdog_clear_o,
  input wire logic              watchdog_overflow_o
);
  // ----------------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------------
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic hit;
  logic wr;
  logic wclr;
  assign hit  = psel && paddr == ADDR_W'(`DCMC_CTRL_ADDR);
  assign wr   = hit && penable && pwrite && pstrb[0];
  assign wclr = wr && pwdata[`DCMC_F_WCLR];
  bit_zero_a: assert property (hit && !pwrite |-> prdata[0] == 1'h0 && prdata[31:8] == 24'h00_0000)
    else $error("ctrl bit zero or upper bits set");
  sleep_stop_a: assert property (wr && pwdata[4:3] == `DCMC_MODE_SLEEP && !wake_i
    |=> ##1 !high_osc_enable_o && slow_osc_enable_o == slow_rc_always_on_i)
    else $error("sleep kept the oscillators on");
  low_only_mode_a: assert property ($fell(slow_osc_enable_o) |-> $past(wr, 2) && $past(pwdata[4:3], 2) == 2'h1)
    else $error("low clock stopped without sleep");
  hstop_a: assert property (wr && pwdata[1] && pwdata[4:3] == 2'h0 && !wake_i
    |=> !high_osc_enable_o && slow_osc_enable_o)
    else $error("high stop bit ignored");
  clr_on_a: assert property (wclr |=> watchdog_clear_o)
    else $error("watchdog clear missing");
  clr_off_a: assert property (watchdog_clear_o |-> $past(wclr))
    else $error("watchdog clear without request");
  clr_quiet_a: assert property (watchdog_clear_o |=> !watchdog_overflow_o [*8])
    else $error("overflow right after clear");
  instr_in_cpu_a: assert property (instr_tick_o |-> cpu_tick_o)
    else $error("instruction tick outside cpu tick");
  tick_gap_a: assert property (cpu_tick_o |=> !cpu_tick_o [*8])
    else $error("shortened cpu tick period");
  in_gpio_a: assert property (osc_in_pin_gpio_o |-> high_clk_option_i == 2'h0)
    else $error("input pin freed in wrong option");
  out_gpio_a: assert property (osc_out_pin_gpio_o |-> high_clk_option_i == 2'h0 || high_clk_option_i == 2'h3)
    else $error("output pin freed in wrong option");
endmodule // dcmc_top_properties

bind dcmc_top dcmc_top_properties #(.ADDR_W(ADDR_W)) u_props (
  .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .wake_i(wake_i),
  .high_clk_option_i(high_clk_option_i), .slow_rc_always_on_i(slow_rc_always_on_i),
  .high_osc_enable_o(high_osc_enable_o), .slow_osc_enable_o(slow_osc_enable_o),
  .osc_in_pin_gpio_o(osc_in_pin_gpio_o), .osc_out_pin_gpio_o(osc_out_pin_gpio_o),
  .cpu_tick_o(cpu_tick_o), .instr_tick_o(instr_tick_o), .watchdog_clear_o(watchdog_clear_o),
  .watchdog_overflow_o(watchdog_overflow_o));

/* bench/tb_dual_clock_mode_control.sv */
// Self-checking bench of dcmc_top with oscillator model and APB master.
// Assumes design, package, checker and model compiled before it.
`timescale 1ns/100ps
`include "dcmc_cfg.svh"
module tb_dual_clock_mode_control;
  // ----------------------------------------------------------------------------
  // Signals, clock, instances
  // ----------------------------------------------------------------------------
  localparam int HF = 3;
  localparam int HX = 4;
  localparam int HS = 3;
  logic        ref_clk_i = 1'h0;
  logic        arst_n_i = 1'h0;
  logic [11:0] paddr = '0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, wake_i = 1'h0, aon = 1'h0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic [3:0]  pstrb = '0;
  logic [1:0]  opt = 2'h0;
  logic        pready, pslverr, fck, xck, sck, hen, sen, ing, outg, ctk, itk, run, wclr, wovf, err;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #2 ref_clk_i = ~ref_clk_i;
  dcmc_osc_model #(.HALF_FAST(HF), .HALF_XTAL(HX), .HALF_SLOW(HS)) u_osc (
    .ref_clk_i(ref_clk_i), .high_osc_enable_i(hen), .slow_osc_enable_i(sen),
    .high_clk_option_i(opt), .fast_rc_clk_o(fck), .osc_in_pin_o(xck), .slow_rc_clk_o(sck));
  dcmc_top #(.ADDR_W(12)) uut (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fast_rc_clk_i(fck), .osc_in_pin_i(xck), .slow_rc_clk_i(sck),
    .wake_i(wake_i), .high_clk_option_i(opt), .slow_rc_always_on_i(aon),
    .high_osc_enable_o(hen), .slow_osc_enable_o(sen), .osc_in_pin_gpio_o(ing),
    .osc_out_pin_gpio_o(outg), .cpu_tick_o(ctk), .instr_tick_o(itk), .cpu_run_o(run),
    .watchdog_clear_o(wclr), .watchdog_overflow_o(wovf));
  // ----------------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog run dominates, and the ceiling sits about a fifth above the whole bench run
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int c, input int lo, input int hi);
    cmp_count++;
    if (c < lo || c > hi) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h..%h", $time, c, lo, hi);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [31:0] r);
    @(posedge ref_clk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    pstrb <= s;
    @(posedge ref_clk_i);
    penable <= 1'h1;
    @(posedge ref_clk_i);
    while (pready !== 1'h1) @(posedge ref_clk_i);
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] d);
    logic [31:0] r;
    apb(1'h1, `DCMC_CTRL_ADDR, d, 4'h1, r);
  endtask
  task automatic rd(input logic [7:0] e);
    logic [31:0] r;
    apb(1'h0, `DCMC_CTRL_ADDR, 8'h00, 4'h0, r);
    chk(r, {24'h00_0000, e});
  endtask
  task automatic rst(input logic [1:0] o, input logic a);
    arst_n_i <= 1'h0;
    opt <= o;
    aon <= a;
    repeat (10) @(posedge ref_clk_i);
    arst_n_i <= 1'h1;
    repeat (6) @(posedge ref_clk_i);
  endtask
  task automatic per(input int e);
    int c;
    repeat (2) begin
      c = 0;
      @(posedge ref_clk_i iff ctk === 1'h1);
      do begin
        @(posedge ref_clk_i);
        c++;
      end while (ctk !== 1'h1);
    end
    rng(c, e, e);
  endtask
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic s_regs();
    logic [31:0] r;
    rd(8'h00);
    apb(1'h1, `DCMC_CTRL_ADDR, 8'hff, 4'h0, r);
    rd(8'h00);
    apb(1'h0, 12'h032c, 8'h00, 4'h0, r);
    chk(r, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    wr(8'h39);
    rd(8'h38);
    chk(32'(run), 32'h0000_0001);
    wr(8'h00);
  endtask
  task automatic s_rate(input logic [1:0] o);
    rst(o, 1'h0);
    chk(32'(ing), 32'(o == 2'h0));
    chk(32'(outg), 32'(o == 2'h0 || o == 2'h3));
    per(o < 2'h2 ? 32 * HF : 8 * HX);
    wr(8'h04);
    per(o == 2'h1 ? 8 * HX : 8 * HS);
    wr(8'h06);
    @(posedge ref_clk_i);
    chk(32'({hen, sen}), 32'h0000_0001);
    per(o == 2'h1 ? 8 * HX : 8 * HS);
  endtask
  task automatic s_green();
    int c;
    rst(2'h2, 1'h0);
    wr(8'h10);
    @(posedge ref_clk_i);
    chk(32'(run), 32'h0000_0000);
    c = 0;
    repeat (200) begin
      @(posedge ref_clk_i);
      c += (itk === 1'h1);
    end
    rng(c, 0, 0);
    per(8 * HX);
    wake_i <= 1'h1;
    repeat (8) @(posedge ref_clk_i);
    wake_i <= 1'h0;
    rd(8'h00);
    chk(32'(run), 32'h0000_0001);
  endtask
  task automatic s_sleep(input logic a);
    int c;
    rst(2'h0, a);
    rd({a, 7'h00});
    wr(8'h08);
    repeat (2) @(posedge ref_clk_i);
    chk(32'({hen, sen}), 32'(a));
    wake_i <= 1'h1;
    c = 0;
    do begin
      @(posedge ref_clk_i);
      c++;
    end while (run !== 1'h1);
    wake_i <= 1'h0;
    rng(c, 4096 * HF, 4096 * HF + 40);
    rd({a, 7'h00});
  endtask
  task automatic s_wdt();
    int c;
    rst(2'h2, 1'h0);
    wr(8'he0);
    @(posedge ref_clk_i);
    chk(32'(wclr), 32'h0000_0001);
    c = 0;
    do begin
      @(posedge ref_clk_i);
      c++;
    end while (wovf !== 1'h1);
    rng(c, 16384 * HS - 2 * HS, 16384 * HS + 4 * HS);
  endtask
  initial begin
    rst(2'h0, 1'h0);
    s_regs();
    for (int o = 0; o < 4; o++) s_rate(2'(o));
    s_green();
    s_sleep(1'h0);
    s_sleep(1'h1);
    s_wdt();
    close_out();
  end
endmodule // tb_dual_clock_mode_control
